/* File: cpu_sub16_pkg.sv */
package cpu_sub16_pkg;
  // opcodes, first byte
  localparam logic [7:0] OP_PREFIX     = 8'h00CF;
  localparam logic [7:0] OP_SUB_HL_IMM = 8'h00D1;
  localparam logic [7:0] OP_SUB_IX_IMM = 8'h00D2;
  localparam logic [7:0] OP_SUB_IY_IMM = 8'h00D3;
  localparam logic [7:0] OP_SWAP_A     = 8'h00F6;
  localparam logic [7:0] OP_SWAP_MEM   = 8'h00F7;
  localparam logic [7:0] OP_UNPACK     = 8'h00DF;
  localparam logic [7:0] OP_XOR_A_A    = 8'h0038;
  localparam logic [7:0] OP_XOR_A_B    = 8'h0039;
  localparam logic [7:0] OP_XOR_A_IMM  = 8'h003A;
  // opcodes, second byte after the prefix
  localparam logic [7:0] OP2_SUB_HL_RP = 8'h0028;
  localparam logic [7:0] OP2_SUB_IX_BA = 8'h0048;
  localparam logic [7:0] OP2_SUB_IX_HL = 8'h0049;
  localparam logic [7:0] OP2_SUB_IY_BA = 8'h004A;
  localparam logic [7:0] OP2_SUB_IY_HL = 8'h004B;
  localparam logic [7:0] OP2_SUB_SP_BA = 8'h004C;
  localparam logic [7:0] OP2_SUB_SP_HL = 8'h004D;
  localparam logic [7:0] OP2_SUB_SP_IMM = 8'h006A;
  // register byte addresses
  localparam logic [7:0] OFF_ACC_PAIR  = 8'h0000;
  localparam logic [7:0] OFF_MEM_PTR   = 8'h0004;
  localparam logic [7:0] OFF_INDEX_ONE = 8'h0008;
  localparam logic [7:0] OFF_INDEX_TWO = 8'h000C;
  localparam logic [7:0] OFF_STACK_PTR = 8'h0010;
  localparam logic [7:0] OFF_FLAGS     = 8'h0014;
  localparam logic [7:0] OFF_PAGE_CTRL = 8'h0018;
  localparam logic [7:0] OFF_STATUS    = 8'h001C;
  // flag bit positions
  localparam int FLAG_Z  = 0;
  localparam int FLAG_C  = 1;
  localparam int FLAG_V  = 2;
  localparam int FLAG_N  = 3;
  // page control field
  localparam int PAGE_LARGE_BIT = 8;
  // reset values
  localparam logic [15:0] RST_PAIR  = 16'h0000;
  localparam logic [7:0]  RST_FLAGS = 8'h0000;
  localparam logic [7:0]  RST_PAGE  = 8'h0000;
  localparam logic [7:0]  PAGE_SMALL = 8'h0000;

  typedef enum logic [1:0] {
    DST_HL,
    DST_IX,
    DST_IY,
    DST_SP
  } dst_e;
endpackage

/* File: cpu_sub16_nibble_xor_exec.sv */
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/100ps
// Contract
// RULE1: CFH 28H-2BH subtracts selected pair from pointer
// RULE2: immediate word subtracted from memory pointer pair
// RULE3: CFH 48H/49H subtracts pair from index one
// RULE4: D2H imm lo,hi subtracts from index one
// RULE5: CFH 4AH/4BH subtracts pair from index two
// RULE6: D3H imm lo,hi subtracts from index two
// RULE7: CFH 4CH/4DH subtracts pair from stack pointer
// RULE8: CFH 6AH imm lo,hi subtracts from stack
// RULE9: F6H swaps accumulator nibbles, flags kept
// RULE10: F7H swaps nibbles of byte at pointer
// RULE11: large models take page from page register
// RULE12: DFH unpacks accumulator into pair, flags kept
// RULE13: 38H/39H xor accumulator or upper byte in
// RULE14: 3AH xors immediate byte into accumulator
// RULE15: word subtract sets N V C Z only
// RULE16: xor sets only N and Z
module cpu_sub16_nibble_xor_exec (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  ibyte_in,
  input  wire logic        ibyte_valid_in,
  output logic             ibyte_ready_out,
  output logic [23:0]      mem_addr_out,
  output logic             mem_rd_out,
  output logic             mem_wr_out,
  output logic [7:0]       mem_wdata_out,
  input  wire logic [7:0]  mem_rdata_in,
  input  wire logic        mem_ack_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out
);
  typedef enum logic [2:0] {S_OP, S_PFX, S_IMM_LO, S_IMM_HI, S_MEM_RD, S_MEM_WR} state_e;
  state_e                  state_q, state_d;
  cpu_sub16_pkg::dst_e     dst_q, dst_d, sub_dst;
  logic                    imm_xor_q, imm_xor_d, large_q, unknown_q;
  logic                    take, do_sub, do_xor, bad_op, bus_req, bus_wr;
  logic [7:0]              imm_lo_q, mem_q, flags_q, flags_d, page_q, xor_b, xor_res;
  logic [15:0]             ba_q, hl_q, ix_q, iy_q, sp_q;
  logic [15:0]             ba_d, hl_d, ix_d, iy_d, sp_d;
  logic [15:0]             sub_a, sub_b, sub_res;
  logic [16:0]             sub_full;

  assign ibyte_ready_out = (state_q != S_MEM_RD) && (state_q != S_MEM_WR);
  assign take            = ibyte_valid_in && ibyte_ready_out;

  // pair selector: 00 acc pair, 01 pointer, 10 index one, 11 index two
  function automatic logic [15:0] pick_pair(input logic [1:0] sel, input logic [15:0] ba,
                                            input logic [15:0] hl, input logic [15:0] ix,
                                            input logic [15:0] iy);
    case (sel)
      2'b00:   pick_pair = ba;
      2'b01:   pick_pair = hl;
      2'b10:   pick_pair = ix;
      default: pick_pair = iy;
    endcase
  endfunction

  function automatic logic [15:0] merge_lanes(input logic [15:0] old, input logic [31:0] wdat,
                                              input logic [3:0] sel);
    merge_lanes = {sel[1] ? wdat[15:8] : old[15:8], sel[0] ? wdat[7:0] : old[7:0]};
  endfunction

  // decode and sequencing
  always_comb begin
    state_d   = state_q;
    dst_d     = dst_q;
    imm_xor_d = imm_xor_q;
    do_sub    = 1'b0;
    sub_dst   = dst_q;
    sub_b     = 16'h0000;
    do_xor    = 1'b0;
    xor_b     = 8'h0000;
    bad_op    = 1'b0;
    case (state_q)
      S_OP: begin
        if (take) begin
          case (ibyte_in)
            cpu_sub16_pkg::OP_PREFIX: begin
              state_d = S_PFX;
            end
            cpu_sub16_pkg::OP_SUB_HL_IMM: begin
              state_d   = S_IMM_LO; // RULE2
              dst_d     = cpu_sub16_pkg::DST_HL;
              imm_xor_d = 1'b0;
            end
            cpu_sub16_pkg::OP_SUB_IX_IMM: begin
              state_d   = S_IMM_LO; // RULE4
              dst_d     = cpu_sub16_pkg::DST_IX;
              imm_xor_d = 1'b0;
            end
            cpu_sub16_pkg::OP_SUB_IY_IMM: begin
              state_d   = S_IMM_LO; // RULE6
              dst_d     = cpu_sub16_pkg::DST_IY;
              imm_xor_d = 1'b0;
            end
            cpu_sub16_pkg::OP_SWAP_MEM: begin
              state_d = S_MEM_RD; // RULE10
            end
            cpu_sub16_pkg::OP_XOR_A_A: begin
              do_xor = 1'b1; // RULE13
              xor_b  = ba_q[7:0];
            end
            cpu_sub16_pkg::OP_XOR_A_B: begin
              do_xor = 1'b1; // RULE13
              xor_b  = ba_q[15:8];
            end
            cpu_sub16_pkg::OP_XOR_A_IMM: begin
              state_d   = S_IMM_LO; // RULE14
              imm_xor_d = 1'b1;
            end
            cpu_sub16_pkg::OP_SWAP_A, cpu_sub16_pkg::OP_UNPACK: state_d = S_OP;
            default: begin
              bad_op = 1'b1;
            end
          endcase
        end
      end
      S_PFX: begin
        if (take) begin
          state_d = S_OP;
          if (ibyte_in[7:2] == cpu_sub16_pkg::OP2_SUB_HL_RP[7:2]) begin
            do_sub  = 1'b1; // RULE1
            sub_dst = cpu_sub16_pkg::DST_HL;
            sub_b   = pick_pair(ibyte_in[1:0], ba_q, hl_q, ix_q, iy_q);
          end else if (ibyte_in[7:1] == cpu_sub16_pkg::OP2_SUB_IX_BA[7:1]) begin
            do_sub  = 1'b1; // RULE3
            sub_dst = cpu_sub16_pkg::DST_IX;
            sub_b   = ibyte_in[0] ? hl_q : ba_q;
          end else if (ibyte_in[7:1] == cpu_sub16_pkg::OP2_SUB_IY_BA[7:1]) begin
            do_sub  = 1'b1; // RULE5
            sub_dst = cpu_sub16_pkg::DST_IY;
            sub_b   = ibyte_in[0] ? hl_q : ba_q;
          end else if (ibyte_in[7:1] == cpu_sub16_pkg::OP2_SUB_SP_BA[7:1]) begin
            do_sub  = 1'b1; // RULE7
            sub_dst = cpu_sub16_pkg::DST_SP;
            sub_b   = ibyte_in[0] ? hl_q : ba_q;
          end else if (ibyte_in == cpu_sub16_pkg::OP2_SUB_SP_IMM) begin
            state_d   = S_IMM_LO; // RULE8
            dst_d     = cpu_sub16_pkg::DST_SP;
            imm_xor_d = 1'b0;
          end else begin
            bad_op = 1'b1;
          end
        end
      end
      S_IMM_LO: begin
        if (take) begin
          if (imm_xor_q) begin
            state_d = S_OP;
            do_xor  = 1'b1; // RULE14
            xor_b   = ibyte_in;
          end else begin
            state_d = S_IMM_HI;
          end
        end
      end
      S_IMM_HI: begin
        if (take) begin
          state_d = S_OP;
          do_sub  = 1'b1; // RULE2 RULE4 RULE6 RULE8
          sub_b   = {ibyte_in, imm_lo_q};
        end
      end
      S_MEM_RD: state_d = mem_ack_in ? S_MEM_WR : S_MEM_RD;
      S_MEM_WR: state_d = mem_ack_in ? S_OP : S_MEM_WR;
      default:  state_d = S_OP;
    endcase
  end

  always_comb begin
    case (sub_dst)
      cpu_sub16_pkg::DST_HL: sub_a = hl_q;
      cpu_sub16_pkg::DST_IX: sub_a = ix_q;
      cpu_sub16_pkg::DST_IY: sub_a = iy_q;
      default:               sub_a = sp_q;
    endcase
  end

  // plain binary difference: no decimal correction even with D or U set
  assign sub_full = {1'b0, sub_a} - {1'b0, sub_b}; // RULE15
  assign sub_res  = sub_full[15:0];
  assign xor_res  = ba_q[7:0] ^ xor_b;

  // bus writes are honoured only between instructions so execution never races software
  assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign bus_wr  = bus_req && wb_we_in && (state_q == S_OP) && !take;

  always_comb begin
    ba_d    = ba_q;
    hl_d    = hl_q;
    ix_d    = ix_q;
    iy_d    = iy_q;
    sp_d    = sp_q;
    flags_d = flags_q;
    if (do_sub) begin
      case (sub_dst)
        cpu_sub16_pkg::DST_HL: hl_d = sub_res;
        cpu_sub16_pkg::DST_IX: ix_d = sub_res;
        cpu_sub16_pkg::DST_IY: iy_d = sub_res;
        default:               sp_d = sub_res;
      endcase
      flags_d[cpu_sub16_pkg::FLAG_N] = sub_res[15]; // RULE15
      flags_d[cpu_sub16_pkg::FLAG_Z] = (sub_res == 16'h0000);
      flags_d[cpu_sub16_pkg::FLAG_C] = sub_full[16];
      flags_d[cpu_sub16_pkg::FLAG_V] = (sub_a[15] ^ sub_b[15]) & (sub_a[15] ^ sub_res[15]);
    end
    if (do_xor) begin
      ba_d[7:0]                      = xor_res;
      flags_d[cpu_sub16_pkg::FLAG_N] = xor_res[7]; // RULE16
      flags_d[cpu_sub16_pkg::FLAG_Z] = (xor_res == 8'h0000);
    end
    if (state_q == S_OP && take && ibyte_in == cpu_sub16_pkg::OP_SWAP_A) begin
      ba_d[7:0] = {ba_q[3:0], ba_q[7:4]}; // RULE9
    end
    if (state_q == S_OP && take && ibyte_in == cpu_sub16_pkg::OP_UNPACK) begin
      ba_d = {4'h0, ba_q[7:4], 4'h0, ba_q[3:0]}; // RULE12
    end
    if (bus_wr) begin
      case (wb_adr_in)
        cpu_sub16_pkg::OFF_ACC_PAIR:  ba_d = merge_lanes(ba_q, wb_dat_in, wb_sel_in);
        cpu_sub16_pkg::OFF_MEM_PTR:   hl_d = merge_lanes(hl_q, wb_dat_in, wb_sel_in);
        cpu_sub16_pkg::OFF_INDEX_ONE: ix_d = merge_lanes(ix_q, wb_dat_in, wb_sel_in);
        cpu_sub16_pkg::OFF_INDEX_TWO: iy_d = merge_lanes(iy_q, wb_dat_in, wb_sel_in);
        cpu_sub16_pkg::OFF_STACK_PTR: sp_d = merge_lanes(sp_q, wb_dat_in, wb_sel_in);
        cpu_sub16_pkg::OFF_FLAGS:     flags_d = wb_sel_in[0] ? wb_dat_in[7:0] : flags_q;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q   <= S_OP;
      dst_q     <= cpu_sub16_pkg::DST_HL;
      imm_xor_q <= 1'b0;
      imm_lo_q  <= 8'h0000;
    end else begin
      state_q   <= state_d;
      dst_q     <= dst_d;
      imm_xor_q <= imm_xor_d;
      if (state_q == S_IMM_LO && take) begin
        imm_lo_q <= ibyte_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ba_q    <= cpu_sub16_pkg::RST_PAIR;
      hl_q    <= cpu_sub16_pkg::RST_PAIR;
      ix_q    <= cpu_sub16_pkg::RST_PAIR;
      iy_q    <= cpu_sub16_pkg::RST_PAIR;
      sp_q    <= cpu_sub16_pkg::RST_PAIR;
      flags_q <= cpu_sub16_pkg::RST_FLAGS;
    end else begin
      ba_q    <= ba_d;
      hl_q    <= hl_d;
      ix_q    <= ix_d;
      iy_q    <= iy_d;
      sp_q    <= sp_d;
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      page_q  <= cpu_sub16_pkg::RST_PAGE;
      large_q <= 1'b0;
    end else if (bus_wr && wb_adr_in == cpu_sub16_pkg::OFF_PAGE_CTRL) begin
      if (wb_sel_in[0]) begin
        page_q <= wb_dat_in[7:0];
      end
      if (wb_sel_in[1]) begin
        large_q <= wb_dat_in[cpu_sub16_pkg::PAGE_LARGE_BIT];
      end
    end
  end

  // sticky, set wins over a status write of one
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      unknown_q <= 1'b0;
    end else if (bad_op) begin
      unknown_q <= 1'b1;
    end else if (bus_wr && wb_adr_in == cpu_sub16_pkg::OFF_STATUS && wb_sel_in[0] && wb_dat_in[0]) begin
      unknown_q <= 1'b0;
    end
  end

  // read-modify-write of the byte at the pointer
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mem_q <= 8'h0000;
    end else if (state_q == S_MEM_RD && mem_ack_in) begin
      mem_q <= {mem_rdata_in[3:0], mem_rdata_in[7:4]}; // RULE10
    end
  end

  assign mem_addr_out  = {large_q ? page_q : cpu_sub16_pkg::PAGE_SMALL, hl_q}; // RULE11
  assign mem_rd_out    = (state_q == S_MEM_RD);
  assign mem_wr_out    = (state_q == S_MEM_WR);
  assign mem_wdata_out = mem_q;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req;
      if (bus_req) begin
        case (wb_adr_in)
          cpu_sub16_pkg::OFF_ACC_PAIR:  wb_dat_out <= {16'h0000, ba_q};
          cpu_sub16_pkg::OFF_MEM_PTR:   wb_dat_out <= {16'h0000, hl_q};
          cpu_sub16_pkg::OFF_INDEX_ONE: wb_dat_out <= {16'h0000, ix_q};
          cpu_sub16_pkg::OFF_INDEX_TWO: wb_dat_out <= {16'h0000, iy_q};
          cpu_sub16_pkg::OFF_STACK_PTR: wb_dat_out <= {16'h0000, sp_q};
          cpu_sub16_pkg::OFF_FLAGS:     wb_dat_out <= {24'h00_0000, flags_q};
          cpu_sub16_pkg::OFF_PAGE_CTRL: wb_dat_out <= {23'h00_0000, large_q, page_q};
          cpu_sub16_pkg::OFF_STATUS:    wb_dat_out <= {30'h0000_0000, (state_q != S_OP), unknown_q};
          default:                      wb_dat_out <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

/* File: cpu_sub16_props.sv */
`timescale 1ns/100ps
module cpu_sub16_props (
  input wire logic       clk_sys_in,
  input wire logic       rst_in,
  input wire logic       ibyte_valid_in,
  input wire logic       ibyte_ready_out,
  input wire logic       mem_rd_out,
  input wire logic       mem_wr_out,
  input wire logic       mem_ack_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [7:0] mem_wdata_out,
  input wire logic       wb_cyc_in,
  input wire logic       wb_stb_in,
  input wire logic       wb_ack_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // read data of the previous cycle, for the swapped write-back
  logic [7:0] rdata_q;
  always_ff @(posedge clk_sys_in) begin
    rdata_q <= mem_rdata_in;
  end
  wb_ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("bus ack longer than one cycle");
  wb_ack_resp_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("bus ack missing after request");
  wb_ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in) && $past(wb_stb_in))
    else $error("bus ack without request");
  swap_write_a: assert property (mem_rd_out && mem_ack_in |=> mem_wr_out && mem_wdata_out == {rdata_q[3:0], rdata_q[7:4]})
    else $error("memory byte not written back swapped");
  mem_stall_a: assert property (mem_rd_out || mem_wr_out |-> !ibyte_ready_out)
    else $error("byte taken during memory access");
  rd_wr_excl_a: assert property (!(mem_rd_out && mem_wr_out))
    else $error("read and write at once");
  rd_hold_a: assert property (mem_rd_out && !mem_ack_in |=> mem_rd_out)
    else $error("read dropped before ack");
  wr_done_a: assert property (mem_wr_out && mem_ack_in |=> !mem_wr_out && ibyte_ready_out)
    else $error("write not finished after ack");
  cover property (mem_wr_out && mem_ack_in);
  cover property (wb_cyc_in && wb_ack_out);
  cover property (ibyte_valid_in && ibyte_ready_out);
endmodule

/* File: tb_cpu_sub16_nibble_xor_exec.sv */
`timescale 1ns/100ps
module tb_cpu_sub16_nibble_xor_exec;
  logic        clk_sys_in = 1'b0;
  logic        rst_in, ibyte_valid_in, ibyte_ready_out, mem_rd_out, mem_wr_out, mem_ack_in;
  logic        wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [7:0]  ibyte_in, mem_wdata_out, mem_rdata_in, wb_adr_in, mem_val;
  logic [23:0] mem_addr_out;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, rd;
  logic [15:0] d, s, e;
  int          fails, checked, n;
  logic [15:0] dv[3] = '{16'h63C2, 16'hC261, 16'h205C};
  logic [15:0] sv[3] = '{16'h2125, 16'h5A32, 16'h7120};
  logic [7:0]  dst_t[14] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h0C, 8'h0C, 8'h0C, 8'h10, 8'h10, 8'h10};
  logic [7:0]  src_t[14] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'hFF, 8'h00, 8'h04, 8'hFF, 8'h00, 8'h04, 8'hFF, 8'h00, 8'h04, 8'hFF};
  logic [7:0]  op_t[14]  = '{8'h28, 8'h29, 8'h2A, 8'h2B, 8'hD1, 8'h48, 8'h49, 8'hD2, 8'h4A, 8'h4B, 8'hD3, 8'h4C, 8'h4D, 8'h6A};
  logic [7:0]  xop[3] = '{8'h38, 8'h39, 8'h3A};
  logic [15:0] xba[3] = '{16'h412C, 16'h412C, 16'h007A};
  logic [15:0] xres[3] = '{16'h4100, 16'h416D, 16'h00CC};
  logic [7:0]  xfl[3] = '{8'hF7, 8'hF6, 8'hFE};

  cpu_sub16_nibble_xor_exec cpu_sub16_nibble_xor_exec_inst (
    .clk_sys_in, .rst_in, .ibyte_in, .ibyte_valid_in, .ibyte_ready_out, .mem_addr_out, .mem_rd_out,
    .mem_wr_out, .mem_wdata_out, .mem_rdata_in, .mem_ack_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
    .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out
  );

  always #12.5 clk_sys_in = ~clk_sys_in;

  // memory side: one-cycle ack; released data lines toggle so stale values never match
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      mem_ack_in   <= 1'b0;
      mem_rdata_in <= 8'h00;
    end else begin
      mem_ack_in   <= (mem_rd_out | mem_wr_out) & ~mem_ack_in;
      mem_rdata_in <= mem_rd_out ? mem_val : ~mem_rdata_in;
    end
  end

  task automatic stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic guard;
    if (n >= 50) begin
      fails++;
      stop_test();
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    n = 0;
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= adr;
    wb_dat_in <= dat;
    do begin @(posedge clk_sys_in); n++; end while (wb_ack_out !== 1'b1 && n < 50);
    guard();
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  // valid stays up between bytes, so back-to-back bytes need no idle edge
  task automatic send(input logic [7:0] b);
    n = 0;
    ibyte_in <= b;
    ibyte_valid_in <= 1'b1;
    do begin @(posedge clk_sys_in); n++; end while (ibyte_ready_out !== 1'b1 && n < 50);
    guard();
  endtask

  task automatic done_instr;
    n = 0;
    ibyte_valid_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    while (ibyte_ready_out !== 1'b1 && n < 50) begin @(posedge clk_sys_in); n++; end
    guard();
  endtask

  initial begin
    {ibyte_valid_in, wb_cyc_in, wb_stb_in, wb_we_in} = '0;
    {ibyte_in, wb_adr_in, mem_val, wb_dat_in} = '0;
    wb_sel_in = 4'hF;
    rst_in = 1'b1;
    fails = 0;
    checked = 0;
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      check(rd, 32'h0);
    end
    for (int i = 0; i < 14; i++) begin
      d = dv[i % 3];
      s = (src_t[i] == dst_t[i]) ? d : sv[i % 3];
      wb(1'b1, dst_t[i], {16'h0, d});
      if (src_t[i] != 8'hFF && src_t[i] != dst_t[i]) wb(1'b1, src_t[i], {16'h0, s});
      wb(1'b1, 8'h14, 32'h00F0);
      if (op_t[i] < 8'hD0) send(8'hCF);
      send(op_t[i]);
      if (src_t[i] == 8'hFF) begin
        send(s[7:0]);
        send(s[15:8]);
      end
      done_instr();
      e = d - s;
      wb(1'b0, dst_t[i], 32'h0);
      check(rd, {16'h0, e});
      wb(1'b0, 8'h14, 32'h0);
      check(rd, {24'h0, 4'hF, e[15], (d[15] != s[15]) && (e[15] != d[15]), d < s, e == 16'h0});
    end
    wb(1'b1, 8'h14, 32'h00A5);
    wb(1'b1, 8'h00, 32'h124C);
    send(8'hF6);
    done_instr();
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h12C4);
    wb(1'b1, 8'h00, 32'hFF84);
    send(8'hDF);
    done_instr();
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0804);
    // high lane only: the low byte must survive a partial write
    wb_sel_in <= 4'h2;
    wb(1'b1, 8'h00, 32'hAB00_3300);
    wb_sel_in <= 4'hF;
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h3304);
    // both page modes: the small model must ignore the page register
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, 8'h04, 32'h1234);
      wb(1'b1, 8'h18, k ? 32'h015A : 32'h005A);
      mem_val = 8'h62;
      send(8'hF7);
      ibyte_valid_in <= 1'b0;
      n = 0;
      do begin @(posedge clk_sys_in); n++; end while (mem_rd_out !== 1'b1 && n < 50);
      guard();
      check(mem_addr_out, {k ? 8'h5A : 8'h00, 16'h1234});
      do begin @(posedge clk_sys_in); n++; end while (mem_wr_out !== 1'b1 && n < 50);
      guard();
      check(mem_wdata_out, 8'h26);
      done_instr();
    end
    wb(1'b0, 8'h14, 32'h0);
    check(rd, 32'h00A5);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, 8'h00, {16'h0, xba[i]});
      wb(1'b1, 8'h14, 32'h00F6);
      send(xop[i]);
      if (xop[i] == 8'h3A) send(8'hB6);
      done_instr();
      wb(1'b0, 8'h00, 32'h0);
      check(rd, {16'h0, xres[i]});
      wb(1'b0, 8'h14, 32'h0);
      check(rd, {24'h0, xfl[i]});
    end
    send(8'h00);
    done_instr();
    wb(1'b0, 8'h1C, 32'h0);
    check(rd, 32'h0000_0001);
    wb(1'b1, 8'h1C, 32'h1);
    wb(1'b0, 8'h1C, 32'h0);
    check(rd, 32'h0000_0000);
    stop_test();
  end
endmodule

bind cpu_sub16_nibble_xor_exec cpu_sub16_props cpu_sub16_props_inst (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ibyte_valid_in(ibyte_valid_in), .ibyte_ready_out(ibyte_ready_out),
  .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in),
  .mem_wdata_out(mem_wdata_out), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out)
);
